/* File: core/core_cache_mmu.v */
// instruction and data caches with their translation buffers
`timescale 1ns/1ns
`default_nettype none
`include "core_cache_mmu_defines.vh"

module core_cache_mmu #(
	parameter TLB_DEPTH = `TLB_ENTRIES
) (
	// clock and reset
	input wire i_clock,
	input wire i_rstn,
	// fetch port
	input wire i_if_req,
	input wire [31:0] i_if_vaddr,
	output wire o_if_ready,
	output wire [31:0] o_if_rdata,
	output wire o_if_tlb_miss,
	output wire o_if_prot_fault,
	// load/store port
	input wire i_ls_req,
	input wire i_ls_we,
	input wire [3:0] i_ls_be,
	input wire [31:0] i_ls_vaddr,
	input wire [31:0] i_ls_wdata,
	output wire o_ls_ready,
	output wire [31:0] o_ls_rdata,
	output wire o_ls_tlb_miss,
	output wire o_ls_prot_fault,
	// translation context
	input wire [3:0] i_asid,
	input wire [7:0] i_grp_allow,
	// translation entry load
	input wire i_tlb_we,
	input wire i_tlb_side,
	input wire [4:0] i_tlb_index,
	input wire i_tlb_valid,
	input wire [19:0] i_tlb_vpn,
	input wire [19:0] i_tlb_ppn,
	input wire [2:0] i_tlb_size,
	input wire [3:0] i_tlb_asid,
	input wire [2:0] i_tlb_grp,
	input wire i_tlb_wt,
	input wire i_tlb_ci,
	// line lock control
	input wire i_lock_req,
	input wire i_lock_cache,
	input wire i_lock_set,
	input wire [31:0] i_lock_paddr,
	// scratch registers
	input wire i_scratch_we,
	input wire [1:0] i_scratch_sel,
	input wire [31:0] i_scratch_wdata,
	output wire [31:0] o_scratch0,
	output wire [31:0] o_scratch1,
	output wire [31:0] o_scratch2,
	// system bus master
	output wire o_bus_req,
	output wire o_bus_we,
	output wire o_bus_burst,
	output wire [31:0] o_bus_addr,
	output wire [31:0] o_bus_wdata,
	output wire [3:0] o_bus_be,
	input wire i_bus_ack,
	input wire [31:0] i_bus_rdata
);

	// storage: index {cache, way, set} for tags, plus word for data
	reg [20:0] tag_reg [0:511];
	reg [31:0] data_reg [0:2047];
	reg [511:0] valid_reg;
	reg [511:0] lock_reg;
	reg [511:0] dirty_reg;
	reg [255:0] lru_reg;
	// translation entries: 0..31 instruction side, 32..63 data side
	reg [19:0] tlb_vpn_reg [0:63];
	reg [19:0] tlb_ppn_reg [0:63];
	reg [2:0] tlb_size_reg [0:63];
	reg [3:0] tlb_asid_reg [0:63];
	reg [2:0] tlb_grp_reg [0:63];
	reg [63:0] tlb_v_reg;
	reg [63:0] tlb_wt_reg;
	reg [63:0] tlb_ci_reg;
	reg [31:0] scratch_reg [0:2];
	// fill engine
	reg [2:0] state_reg;
	reg owner_reg;
	reg way_reg;
	reg [1:0] beat_reg;
	reg [1:0] start_reg;
	reg [31:0] base_reg;
	reg [20:0] wb_tag_reg;
	reg [31:0] wdata_reg;
	reg [3:0] be_reg;
	// one loop variable per process, so no variable has two drivers
	integer k;
	integer j;
	integer m;

	// page size decode, shared by compare and address build
	function [19:0] page_mask;
		input [2:0] sz;
		begin
			case (sz)
				`PSIZE_16K: page_mask = `PMASK_16K;
				`PSIZE_256K: page_mask = `PMASK_256K;
				`PSIZE_512K: page_mask = `PMASK_512K;
				`PSIZE_8M: page_mask = `PMASK_8M;
				default: page_mask = `PMASK_4K;
			endcase
		end
	endfunction

	// associative search
	// every entry compares in parallel; space and masked page number must agree
	wire [63:0] tlb_hit;
	genvar g;
	generate
		for (g = 0; g < 64; g = g + 1)
		begin : tlb_cmp
			wire [31:0] va = (g < 32) ? i_if_vaddr : i_ls_vaddr;
			assign tlb_hit[g] = tlb_v_reg[g] & (tlb_asid_reg[g] == i_asid) &
				(((va[31:12] ^ tlb_vpn_reg[g]) & page_mask(tlb_size_reg[g])) == 20'h00000);
		end
	endgenerate

	// entry select; software keeps entries non-overlapping so one hit is expected
	reg [4:0] if_idx;
	reg [4:0] ls_idx;
	always @*
	begin
		if_idx = 5'h00;
		ls_idx = 5'h00;
		for (j = 0; j < 32; j = j + 1)
		begin
			if (tlb_hit[j])
				if_idx = j[4:0];
			if (tlb_hit[j + 32])
				ls_idx = j[4:0];
		end
	end

	// physical address: page bits from the entry, offset bits from the request
	wire [5:0] if_ent = {1'b0, if_idx};
	wire [5:0] ls_ent = {1'b1, ls_idx};
	wire [19:0] if_mask = page_mask(tlb_size_reg[if_ent]);
	wire [19:0] ls_mask = page_mask(tlb_size_reg[ls_ent]);
	wire [31:0] if_pa = {(tlb_ppn_reg[if_ent] & if_mask) | (i_if_vaddr[31:12] & ~if_mask),
		i_if_vaddr[11:0]};
	wire [31:0] ls_pa = {(tlb_ppn_reg[ls_ent] & ls_mask) | (i_ls_vaddr[31:12] & ~ls_mask),
		i_ls_vaddr[11:0]};
	wire if_thit = |tlb_hit[31:0];
	wire ls_thit = |tlb_hit[63:32];
	wire if_perm = i_grp_allow[tlb_grp_reg[if_ent]];
	wire ls_perm = i_grp_allow[tlb_grp_reg[ls_ent]];
	wire if_ok = i_if_req & if_thit & if_perm;
	wire ls_ok = i_ls_req & ls_thit & ls_perm;
	wire if_ci = tlb_ci_reg[if_ent];
	wire ls_ci = tlb_ci_reg[ls_ent];
	wire ls_wt = tlb_wt_reg[ls_ent];
	assign o_if_tlb_miss = i_if_req & ~if_thit;
	assign o_ls_tlb_miss = i_ls_req & ~ls_thit;
	assign o_if_prot_fault = i_if_req & if_thit & ~if_perm;
	assign o_ls_prot_fault = i_ls_req & ls_thit & ~ls_perm;

	// physical lookup
	// both caches look up at once, indexed and tagged by physical address
	wire [3:0] way_hit;
	wire [63:0] rd_word;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : lookup
			localparam [0:0] CB = (g == 1) ? 1'b1 : 1'b0;
			wire [31:0] pa = (g == 0) ? if_pa : ls_pa;
			wire [8:0] t0 = {CB, 1'b0, pa[`SET_MSB:`SET_LSB]};
			wire [8:0] t1 = {CB, 1'b1, pa[`SET_MSB:`SET_LSB]};
			assign way_hit[2 * g] = valid_reg[t0] & (tag_reg[t0] == pa[31:`TAG_LSB]);
			assign way_hit[2 * g + 1] = valid_reg[t1] & (tag_reg[t1] == pa[31:`TAG_LSB]);
			assign rd_word[32 * g +: 32] = way_hit[2 * g + 1] ?
				data_reg[{CB, 1'b1, pa[`SET_MSB:2]}] : data_reg[{CB, 1'b0, pa[`SET_MSB:2]}];
		end
	endgenerate

	wire if_hit = if_ok & ~if_ci & (|way_hit[1:0]);
	wire ls_hit = ls_ok & ~ls_ci & (|way_hit[3:2]);
	wire idle = (state_reg == `ST_IDLE);
	// write policy
	// write-through stores always go out; copy-back stores finish in the cache unless both ways of their set are locked
	wire d_need = ls_ok & (ls_ci | ~(|way_hit[3:2]) | (i_ls_we & ls_wt));
	wire i_need = if_ok & (if_ci | ~(|way_hit[1:0]));
	wire start_c = d_need;
	wire [31:0] spa = start_c ? ls_pa : if_pa;
	wire [7:0] lru_idx = {start_c, spa[`SET_MSB:`SET_LSB]};
	wire lru_way = lru_reg[lru_idx];
	wire vic = lock_reg[{start_c, lru_way, spa[`SET_MSB:`SET_LSB]}] ? ~lru_way : lru_way;
	wire [8:0] vidx = {start_c, vic, spa[`SET_MSB:`SET_LSB]};
	wire can_alloc = ~lock_reg[vidx];
	wire single = start_c ? (ls_ci | (i_ls_we & ls_wt) | ~can_alloc) : (if_ci | ~can_alloc);
	wire go = idle & (d_need | i_need);
	wire fill_go = go & ~single;
	wire [1:0] fill_word = start_reg + beat_reg;
	wire beat_ack = i_bus_ack & ((state_reg == `ST_WB) | (state_reg == `ST_FILL));
	wire last_beat = beat_ack & (beat_reg == 2'h3);
	wire single_ack = i_bus_ack & ((state_reg == `ST_SWR) | (state_reg == `ST_SRD));

	// critical word first
	// the wanted word leads the burst and answers the fetch on arrival
	wire if_miss_ans = ~owner_reg & i_bus_ack & (((state_reg == `ST_FILL) & (beat_reg == 2'h0)) |
		(state_reg == `ST_SRD));
	assign o_if_ready = if_hit | (if_ok & if_miss_ans);
	assign o_if_rdata = if_hit ? rd_word[31:0] : i_bus_rdata;
	// miss extra clock
	// after a data fill the held request hits on the following cycle
	wire ls_store_hit = ls_hit & i_ls_we;
	assign o_ls_ready = (ls_hit & ~(i_ls_we & ls_wt)) | (ls_ok & owner_reg & single_ack);
	assign o_ls_rdata = ls_hit ? rd_word[63:32] : i_bus_rdata;

	// bus side follows the engine registers
	assign o_bus_req = ~idle;
	assign o_bus_we = (state_reg == `ST_WB) | (state_reg == `ST_SWR);
	assign o_bus_burst = (state_reg == `ST_WB) | (state_reg == `ST_FILL);
	assign o_bus_addr = (state_reg == `ST_WB) ?
		{wb_tag_reg, base_reg[`SET_MSB:`SET_LSB], beat_reg, 2'b00} :
		(state_reg == `ST_FILL) ? {base_reg[31:4], fill_word, 2'b00} : base_reg;
	assign o_bus_wdata = (state_reg == `ST_WB) ?
		data_reg[{owner_reg, way_reg, base_reg[`SET_MSB:`SET_LSB], beat_reg}] : wdata_reg;
	assign o_bus_be = (state_reg == `ST_SWR) ? be_reg : 4'hf;
	assign o_scratch0 = scratch_reg[0];
	assign o_scratch1 = scratch_reg[1];
	assign o_scratch2 = scratch_reg[2];

	// control state, line status bits and the fill engine
	always @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_reg <= `ST_IDLE;
			owner_reg <= 1'b0;
			way_reg <= 1'b0;
			beat_reg <= 2'h0;
			start_reg <= 2'h0;
			base_reg <= 32'h00000000;
			wb_tag_reg <= 21'h00000;
			wdata_reg <= 32'h00000000;
			be_reg <= 4'h0;
			valid_reg <= {512{1'b0}};
			lock_reg <= {512{1'b0}};
			dirty_reg <= {512{1'b0}};
			lru_reg <= {256{1'b0}};
			tlb_v_reg <= 64'h0000000000000000;
			tlb_wt_reg <= 64'h0000000000000000;
			tlb_ci_reg <= 64'h0000000000000000;
			for (k = 0; k < 3; k = k + 1)
				scratch_reg[k] <= 32'h00000000;
		end
		else
		begin
			if (i_scratch_we && i_scratch_sel != 2'h3)
				scratch_reg[i_scratch_sel] <= i_scratch_wdata;
			if (i_tlb_we)
			begin
				tlb_v_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_valid;
				tlb_wt_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_wt;
				tlb_ci_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_ci;
			end
			// line lock
			// only a resident line can be locked; a miss is silently ignored
			if (i_lock_req)
				for (k = 0; k < 2; k = k + 1)
					if (valid_reg[{i_lock_cache, k[0], i_lock_paddr[`SET_MSB:`SET_LSB]}] &&
						tag_reg[{i_lock_cache, k[0], i_lock_paddr[`SET_MSB:`SET_LSB]}] ==
						i_lock_paddr[31:`TAG_LSB])
						lock_reg[{i_lock_cache, k[0], i_lock_paddr[`SET_MSB:`SET_LSB]}] <= i_lock_set;
			// hits make the other way least recently used
			if (if_hit)
				lru_reg[{1'b0, if_pa[`SET_MSB:`SET_LSB]}] <= ~way_hit[1];
			if (ls_hit)
				lru_reg[{1'b1, ls_pa[`SET_MSB:`SET_LSB]}] <= ~way_hit[3];
			if (ls_store_hit && !ls_wt)
				dirty_reg[{1'b1, way_hit[3], ls_pa[`SET_MSB:`SET_LSB]}] <= 1'b1;
			case (state_reg)
				`ST_IDLE:
				begin
					if (go)
					begin
						owner_reg <= start_c;
						base_reg <= spa;
						start_reg <= spa[3:2];
						beat_reg <= 2'h0;
						way_reg <= vic;
						wdata_reg <= i_ls_wdata;
						be_reg <= i_ls_be;
						wb_tag_reg <= tag_reg[vidx];
						if (single)
							state_reg <= (start_c && i_ls_we) ? `ST_SWR : `ST_SRD;
						else
						begin
							// victim goes invalid so nothing hits a half-filled line
							valid_reg[vidx] <= 1'b0;
							dirty_reg[vidx] <= 1'b0;
							state_reg <= (valid_reg[vidx] && dirty_reg[vidx]) ? `ST_WB : `ST_FILL;
						end
					end
				end
				`ST_WB:
				begin
					if (beat_ack)
						beat_reg <= beat_reg + 2'h1;
					if (last_beat)
						state_reg <= `ST_FILL;
				end
				`ST_FILL:
				begin
					if (beat_ack)
						beat_reg <= beat_reg + 2'h1;
					if (last_beat)
					begin
						valid_reg[{owner_reg, way_reg, base_reg[`SET_MSB:`SET_LSB]}] <= 1'b1;
						lru_reg[{owner_reg, base_reg[`SET_MSB:`SET_LSB]}] <= ~way_reg;
						state_reg <= `ST_IDLE;
					end
				end
				`ST_SWR,
				`ST_SRD:
				begin
					if (single_ack)
						state_reg <= `ST_IDLE;
				end
				default:
					state_reg <= `ST_IDLE;
			endcase
		end
	end

	// wide storage carries no reset; valid bits guard every read
	always @(posedge i_clock)
	begin
		if (fill_go)
			tag_reg[vidx] <= spa[31:`TAG_LSB];
		if ((state_reg == `ST_FILL) && i_bus_ack)
			data_reg[{owner_reg, way_reg, base_reg[`SET_MSB:`SET_LSB], fill_word}] <= i_bus_rdata;
		if (ls_store_hit)
			for (m = 0; m < 4; m = m + 1)
				if (i_ls_be[m])
					data_reg[{1'b1, way_hit[3], ls_pa[`SET_MSB:2]}][8 * m +: 8] <=
						i_ls_wdata[8 * m +: 8];
		if (i_tlb_we)
		begin
			tlb_vpn_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_vpn;
			tlb_ppn_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_ppn;
			tlb_size_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_size;
			tlb_asid_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_asid;
			tlb_grp_reg[{i_tlb_side, i_tlb_index}] <= i_tlb_grp;
		end
	end

endmodule
`default_nettype wire

/* File: dv/bus_mem_model.sv */
// behavioural system memory answering the block's bus master
`timescale 1ns/1ns
`default_nettype none
module bus_mem_model (
	// clock, reset and pacing
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [1:0] i_wait,
	// bus from the block
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_be,
	// answer
	output logic o_ack,
	output logic [31:0] o_rdata
);
	logic [31:0] mem [0:1023];
	logic [31:0] key, cur, m;
	logic [1:0] cnt_reg;
	// words read as page number over word index until written, so a wrong page shows
	assign key = {i_addr[31:12], 12'h000};
	assign cur = mem[i_addr[11:2]] ^ key;
	assign m = {{8{i_be[3]}}, {8{i_be[2]}}, {8{i_be[1]}}, {8{i_be[0]}}};
	initial
		for (int i = 0; i < 1024; i++)
			mem[i] = i;
	// one beat per ack; idle data toggles so a stale word never matches
	always @(posedge i_clock or negedge i_rstn)
		if (!i_rstn)
		begin
			o_ack <= 1'b0;
			o_rdata <= 32'h0;
			cnt_reg <= 2'h0;
		end
		else if (o_ack)
		begin
			if (i_we)
				mem[i_addr[11:2]] <= ((i_wdata & m) | (cur & ~m)) ^ key;
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			cnt_reg <= 2'h0;
		end
		else if (i_req && cnt_reg == i_wait)
		begin
			o_ack <= 1'b1;
			o_rdata <= cur;
		end
		else
		begin
			o_rdata <= ~o_rdata;
			cnt_reg <= cnt_reg + {1'b0, i_req};
		end
endmodule
`default_nettype wire

/* File: dv/core_cache_mmu_properties.sv */
// port-level assertions for the cache and translation block
`timescale 1ns/1ns
`default_nettype none
module core_cache_mmu_properties (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// core ports
	input wire logic i_if_req,
	input wire logic o_if_ready,
	input wire logic o_if_tlb_miss,
	input wire logic o_if_prot_fault,
	input wire logic i_ls_req,
	input wire logic o_ls_ready,
	input wire logic o_ls_tlb_miss,
	input wire logic o_ls_prot_fault,
	// scratch registers
	input wire logic i_scratch_we,
	input wire logic [1:0] i_scratch_sel,
	input wire logic [31:0] i_scratch_wdata,
	input wire logic [31:0] o_scratch0,
	input wire logic [31:0] o_scratch1,
	input wire logic [31:0] o_scratch2,
	// system bus
	input wire logic o_bus_req,
	input wire logic o_bus_we,
	input wire logic o_bus_burst,
	input wire logic [31:0] o_bus_addr,
	input wire logic [3:0] o_bus_be,
	input wire logic i_bus_ack
);
	// one clock domain, so one default clocking and reset
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);
	a_if_ready_req: assert property (o_if_ready |-> i_if_req)
		else $error("fetch ready without request");
	a_ls_ready_req: assert property (o_ls_ready |-> i_ls_req)
		else $error("load store ready without request");
	a_if_refused: assert property ((o_if_tlb_miss || o_if_prot_fault) |-> !o_if_ready)
		else $error("refused fetch completed");
	a_ls_refused: assert property ((o_ls_tlb_miss || o_ls_prot_fault) |-> !o_ls_ready)
		else $error("refused data access completed");
	// the bus beat must not move before it is taken
	a_bus_beat_hold: assert property (o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr))
		else $error("bus beat changed before ack");
	a_fill_wraps: assert property ((o_bus_req && o_bus_burst && !o_bus_we && i_bus_ack) ##1
		(o_bus_req && o_bus_burst && !o_bus_we) |-> o_bus_addr[31:4] == $past(o_bus_addr[31:4])
		&& o_bus_addr[3:2] == $past(o_bus_addr[3:2]) + 2'h1)
		else $error("fill beat not next word of line");
	a_burst_full_be: assert property (o_bus_req && o_bus_burst |-> o_bus_be == 4'hf)
		else $error("line burst without all byte enables");
	a_scratch_load: assert property (i_scratch_we && i_scratch_sel == 2'h1
		|=> o_scratch1 == $past(i_scratch_wdata))
		else $error("scratch write not taken");
	a_scratch_skip: assert property (i_scratch_we && i_scratch_sel == 2'h3
		|=> $stable(o_scratch0) && $stable(o_scratch1) && $stable(o_scratch2))
		else $error("unused scratch select changed a register");
	c_fetch_fill: cover property (o_if_ready && o_bus_req && i_bus_ack);
	c_single_write: cover property (o_bus_req && o_bus_we && !o_bus_burst && i_bus_ack);
	c_prot_fault: cover property (o_if_prot_fault);
endmodule
`default_nettype wire

/* File: dv/core_cache_mmu_tb.sv */
// self-checking bench for the cache and translation block
`timescale 1ns/1ns
`default_nettype none
module core_cache_mmu_tb;
	logic i_clock, i_rstn, i_if_req, i_ls_req, i_ls_we, i_tlb_we, i_tlb_side, i_tlb_valid;
	logic i_tlb_wt, i_tlb_ci, i_lock_req, i_lock_cache, i_lock_set, i_scratch_we;
	logic [31:0] i_if_vaddr, i_ls_vaddr, i_ls_wdata, i_lock_paddr, i_scratch_wdata;
	logic [19:0] i_tlb_vpn, i_tlb_ppn;
	logic [7:0] i_grp_allow;
	logic [4:0] i_tlb_index;
	logic [3:0] i_ls_be, i_asid, i_tlb_asid;
	logic [2:0] i_tlb_size, i_tlb_grp;
	logic [1:0] i_scratch_sel, wait_cycles;
	wire o_if_ready, o_if_tlb_miss, o_if_prot_fault, o_ls_ready, o_ls_tlb_miss;
	wire o_ls_prot_fault, o_bus_req, o_bus_we, o_bus_burst, i_bus_ack;
	wire [31:0] o_if_rdata, o_ls_rdata, o_scratch0, o_scratch1, o_scratch2;
	wire [31:0] o_bus_addr, o_bus_wdata, i_bus_rdata;
	wire [3:0] o_bus_be;
	int fail_count = 0;
	int total_checks = 0;
	int beats = 0;
	int cycles = 0;
	core_cache_mmu dut (.*);
	bus_mem_model mem (.i_clock, .i_rstn, .i_wait(wait_cycles), .i_req(o_bus_req),
		.i_we(o_bus_we), .i_addr(o_bus_addr), .i_wdata(o_bus_wdata), .i_be(o_bus_be),
		.o_ack(i_bus_ack), .o_rdata(i_bus_rdata));
	// clock, beat count and hang guard
	initial
	begin
		i_clock = 0;
		forever #25 i_clock = ~i_clock;
	end
	always @(posedge i_clock)
	begin
		beats += i_bus_ack;
		cycles++;
		if (cycles == 8000)
		begin
			fail_count++;
			test_done;
		end
	end
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[31:12], 2'b00, a[11:2]};
	endfunction
	task step;
		@(posedge i_clock);
		#1;
	endtask
	task automatic map(input logic sd, input logic [4:0] ix, input logic [19:0] vp, pp,
			input logic [2:0] sz, input logic [3:0] as, input logic [2:0] gp, input logic wt, ci);
		{i_tlb_side, i_tlb_index, i_tlb_vpn, i_tlb_ppn} = {sd, ix, vp, pp};
		{i_tlb_size, i_tlb_asid, i_tlb_grp, i_tlb_wt, i_tlb_ci} = {sz, as, gp, wt, ci};
		i_tlb_we = 1;
		step;
		i_tlb_we = 0;
	endtask
	// one access on either port; request held until ready, then the fill is let finish
	task automatic acc(input logic p, we, input logic [3:0] be, input logic [31:0] va, wd,
			output int lat, output logic [31:0] d, output logic [1:0] f);
		lat = 99;
		{i_ls_we, i_ls_be, i_ls_wdata} = {we, be, wd};
		if (p)
			{i_ls_req, i_ls_vaddr} = {1'b1, va};
		else
			{i_if_req, i_if_vaddr} = {1'b1, va};
		for (int n = 0; n < 40 && lat == 99; n++)
		begin
			@(negedge i_clock);
			if (n == 0)
				f = p ? {o_ls_tlb_miss, o_ls_prot_fault} : {o_if_tlb_miss, o_if_prot_fault};
			if ((p ? o_ls_ready : o_if_ready) === 1'b1)
			begin
				lat = n;
				d = p ? o_ls_rdata : o_if_rdata;
			end
			step;
		end
		{i_if_req, i_ls_req} = 2'b00;
		repeat (10) step;
	endtask
	task automatic t_reset_scratch;
		int lat;
		logic [31:0] d;
		logic [1:0] f;
		chk(o_bus_req, 0);
		chk(o_scratch1, 0);
		acc(0, 0, 4'hf, 32'h1000, 0, lat, d, f);
		chk(f, 2'b10);
		chk(lat, 99);
		for (int s = 0; s < 4; s++)
		begin
			{i_scratch_sel, i_scratch_wdata, i_scratch_we} = {2'(s), 32'ha5000000 + s, 1'b1};
			step;
			i_scratch_we = 0;
		end
		chk(o_scratch0, 32'ha5000000);
		chk(o_scratch1, 32'ha5000001);
		chk(o_scratch2, 32'ha5000002);
	endtask
	// every page size, probed at its last word so the mask width matters
	task automatic t_pages;
		int lat;
		logic [31:0] d, va, pa;
		logic [1:0] f;
		int off [5] = '{32'hffc, 32'h3ffc, 32'h3fffc, 32'h7fffc, 32'h7ffffc};
		for (int s = 0; s < 5; s++)
		begin
			map(0, 5'(s), 20'((s + 1) << 12), 20'((s + 9) << 11), 3'(s), 4'h0, 3'h0, 0, 0);
			va = 32'((s + 1) << 24) + off[s];
			pa = 32'((s + 9) << 23) + off[s];
			acc(0, 0, 4'hf, va, 0, lat, d, f);
			chk(d, pat(pa));
			chk(lat, 2);
			acc(0, 0, 4'hf, va, 0, lat, d, f);
			chk(lat, 0);
			chk(d, pat(pa));
		end
	endtask
	task automatic t_prot;
		int lat;
		logic [31:0] d;
		logic [1:0] f;
		map(0, 10, 20'h00fff, 20'h00aaa, 3'h0, 4'h3, 3'h5, 0, 0);
		{i_asid, i_grp_allow} = {4'h3, 8'hdf};
		acc(0, 0, 4'hf, 32'h00fff010, 0, lat, d, f);
		chk(f, 2'b01);
		{i_asid, i_grp_allow} = {4'h4, 8'hff};
		acc(0, 0, 4'hf, 32'h00fff010, 0, lat, d, f);
		chk(f, 2'b10);
		i_asid = 4'h3;
		acc(0, 0, 4'hf, 32'h00fff010, 0, lat, d, f);
		chk(d, pat(32'h00aaa010));
		i_asid = 4'h0;
	endtask
	// copy-back, write-through and inhibited pages side by side
	task automatic t_dpol;
		int lat, b0;
		logic [31:0] d;
		logic [1:0] f;
		map(1, 0, 20'h00800, 20'h00800, 3'h4, 4'h0, 3'h0, 0, 0);
		map(1, 1, 20'h01000, 20'h01000, 3'h4, 4'h0, 3'h0, 1, 0);
		map(1, 2, 20'h01800, 20'h01800, 3'h4, 4'h0, 3'h0, 0, 1);
		acc(1, 0, 4'hf, 32'h00800000, 0, lat, d, f);
		chk(lat, 9);
		chk(d, pat(32'h00800000));
		b0 = beats;
		acc(1, 1, 4'hf, 32'h00800000, 32'hdeadbeef, lat, d, f);
		acc(1, 0, 4'hf, 32'h00800000, 0, lat, d, f);
		chk(lat, 0);
		chk(d, 32'hdeadbeef);
		chk(beats - b0, 0);
		acc(1, 0, 4'hf, 32'h01000000, 0, lat, d, f);
		b0 = beats;
		acc(1, 1, 4'h3, 32'h01000000, 32'h12345678, lat, d, f);
		chk(beats - b0, 1);
		acc(1, 0, 4'hf, 32'h01000000, 0, lat, d, f);
		chk(d, {pat(32'h01000000) >> 16, 16'h5678});
		b0 = beats;
		repeat (2) acc(1, 0, 4'hf, 32'h01800004, 0, lat, d, f);
		chk(beats - b0, 2);
		chk(d, pat(32'h01800004));
	endtask
	// three lines of one set: lru victim, then a locked line survives
	task automatic t_lru;
		int lat;
		logic [31:0] d;
		logic [1:0] f;
		logic [31:0] a [3] = '{32'h00800010, 32'h00800810, 32'h00801010};
		int seq [6] = '{0, 1, 0, 2, 0, 1};
		int want [6] = '{1, 1, 0, 1, 0, 1};
		for (int i = 0; i < 6; i++)
		begin
			acc(1, 0, 4'hf, a[seq[i]], 0, lat, d, f);
			chk(lat != 0, want[i]);
		end
		{i_lock_cache, i_lock_set, i_lock_paddr, i_lock_req} = {1'b1, 1'b1, a[0], 1'b1};
		step;
		i_lock_req = 0;
		acc(1, 0, 4'hf, a[1], 0, lat, d, f);
		acc(1, 0, 4'hf, a[2], 0, lat, d, f);
		acc(1, 0, 4'hf, a[0], 0, lat, d, f);
		chk(lat, 0);
		chk(d, pat(a[0]));
	endtask
	initial
	begin
		{i_if_req, i_ls_req, i_ls_we, i_tlb_we, i_tlb_side, i_tlb_valid, i_tlb_wt} = '0;
		{i_tlb_ci, i_lock_req, i_lock_cache, i_lock_set, i_scratch_we, i_if_vaddr} = '0;
		{i_ls_vaddr, i_ls_wdata, i_lock_paddr, i_scratch_wdata, i_tlb_vpn} = '0;
		{i_tlb_ppn, i_tlb_index, i_ls_be, i_asid, i_tlb_asid, i_tlb_size} = '0;
		{i_tlb_grp, i_scratch_sel, wait_cycles, i_rstn} = '0;
		i_tlb_valid = 1;
		i_grp_allow = 8'hff;
		repeat (16) @(posedge i_clock);
		#1 i_rstn = 1;
		t_reset_scratch;
		t_pages;
		t_prot;
		t_dpol;
		t_lru;
		test_done;
	end
endmodule
bind core_cache_mmu core_cache_mmu_properties chk_i (.*);
`default_nettype wire

/* File: shared/core_cache_mmu_defines.vh */
// constants for the core cache and translation block
`ifndef CORE_CACHE_MMU_DEFINES_VH
`define CORE_CACHE_MMU_DEFINES_VH
// cache geometry: 4 kbyte, two ways, four-word lines, 128 sets per way
`define CACHE_BYTES 4096
`define LINE_WORDS 4
`define SET_LSB 4
`define SET_MSB 10
`define TAG_LSB 11
// translation buffers
`define TLB_ENTRIES 32
`define ASID_BITS 4
`define PGRP_COUNT 8
// page size codes
`define PSIZE_4K 3'h0
`define PSIZE_16K 3'h1
`define PSIZE_256K 3'h2
`define PSIZE_512K 3'h3
`define PSIZE_8M 3'h4
// page-number compare masks over address bits 31..12
`define PMASK_4K 20'hfffff
`define PMASK_16K 20'hffffc
`define PMASK_256K 20'hfffc0
`define PMASK_512K 20'hfff80
`define PMASK_8M 20'hff800
// engine state codes
`define ST_IDLE 3'h0
`define ST_WB 3'h1
`define ST_FILL 3'h2
`define ST_SWR 3'h3
`define ST_SRD 3'h4
`endif
